// file: hw/enclave_exit_state_save_frame.sv
// Function
// RULE1: on async exit, save state into frame chosen by current_frame_index.
// RULE2: software places every save frame on a page boundary.
// RULE3: extended_state_image written from byte 0 of the frame, non-compacted.
// RULE4: image size comes from enabled components with enumeration size info.
// RULE5: general_reg_save_region is the last 176 bytes of the frame.
// RULE6: software sizes pad so the register region ends on a 4KB page end.
// RULE7: extended-info region only if enumeration nonzero; sits right below register region.
// RULE8: gap below extended-info (or register) region up to image is software pad.
// RULE9: sixteen general registers at offsets 0..120, 8 bytes each, architectural order.
// RULE10: flags at 128, instruction pointer at 136, 8 bytes each.
// RULE11: outside stack pointer at 144: captured on entry, restored on exit.
// RULE12: outside frame pointer at 152: captured on entry, restored on exit.
// RULE13: 4-byte exit_reason_word at 160, then 4 reserved bytes.
// RULE14: register region holds registers, ip, outside pointers, flags, exit info together.
// RULE15: segment bases at 168 and 176; true region size must be confirmed; the code writes only the base at 168.
// RULE16: frame address = container base + save_stack_offset + index * save_frame_length.
// RULE17: index increments on each async exit, decrements on each resume; the code leaves an index of 0 unchanged on resume.
// RULE18: entry fails unless a free save frame remains for the thread.
// RULE19: extended-info component i saved only when selection bit i set.
`timescale 1ns/100ps
module enclave_exit_state_save_frame
    import frame_save_pkg::*;
(
    input  wire logic              mclk,             // core clock
    input  wire logic              rst_b,            // async reset, active low
    input  wire logic              async_exit_req,   // async_container_exit request, pulse
    input  wire logic              entry_req,        // container_entry_instruction, pulse
    input  wire logic              resume_req,       // container_resume_instruction, pulse
    input  wire logic [63:0]       container_base,   // container base address
    input  wire logic [63:0]       save_stack_offset, // frame stack offset from base
    input  wire logic [31:0]       save_frame_length, // bytes per frame
    input  wire logic [31:0]       frame_slot_count, // frames available to the thread
    input  wire logic [31:0]       xs_size_bytes,    // image size for enabled components
    input  wire logic [63:0]       xs_data,          // image word at xs_idx
    input  wire logic [31:0]       misc_enum,        // supported extended-info components
    input  wire logic [31:0]       extended_info_select, // container's selection bits
    input  wire logic [63:0]       misc_fault_addr,  // component 0 fault address
    input  wire logic [31:0]       misc_err_code,    // component 0 error code
    input  wire logic [15:0][63:0] gpr_val,          // general registers, arch order
    input  wire logic [63:0]       flags_val,        // flags register
    input  wire logic [63:0]       ip_val,           // instruction pointer
    input  wire logic [31:0]       exit_reason_word, // exit reason of this exit
    input  wire logic [63:0]       seg_base_first,   // first_extra_segment_base
    input  wire logic [63:0]       cur_sp,           // stack pointer at entry
    input  wire logic [63:0]       cur_fp,           // frame pointer at entry
    input  wire logic              mem_ready,        // memory takes the write this cycle
    output logic                   mem_wr,           // write request, held until taken
    output logic [63:0]            mem_addr,         // byte address, 8-aligned
    output logic [63:0]            mem_wdata,        // write word
    output logic [28:0]            xs_idx,           // image word being fetched
    output logic                   busy,             // save in progress
    output logic                   save_done,        // save finished, pulse
    output logic                   entry_ok,         // entry accepted, pulse
    output logic                   entry_fail,       // entry refused, pulse
    output logic                   restore_valid,    // restore pointers now, pulse
    output logic [63:0]            restore_sp,       // outside stack pointer to restore
    output logic [63:0]            restore_fp,       // outside frame pointer to restore
    output logic [31:0]            current_frame_index // thread frame index
);

    typedef struct packed {
        save_state_t st;
        logic [28:0] cnt;
        logic [31:0] idx;
        logic [63:0] frame;
        logic [63:0] gpr_base;
        logic [63:0] osp;
        logic [63:0] ofp;
        logic        wr;
        logic [63:0] addr;
        logic [63:0] wdata;
        logic        done;
        logic        ok;
        logic        fail;
        logic        rv;
        // busy gets its own flop so the pin is never a decode of the state code
        logic        bsy;
    } save_s_t;

    localparam save_s_t S_RST = '{st: ST_IDLE, default: '0};

    save_s_t     s_reg;
    save_s_t     s_next;
    logic        stall;
    logic        misc_on;
    logic [28:0] xs_words;
    logic [63:0] slot_ofs;

    assign stall    = s_reg.wr && !mem_ready;
    assign xs_words = xs_size_bytes[31:WORD_SHIFT];                       // [RULE4]
    // only component 0 is defined; any higher selection bit has no layout to write
    assign misc_on  = (misc_enum != 32'h0)
                      && extended_info_select[MISC_COMP0_BIT];           // [RULE7] [RULE19]
    assign slot_ofs = {32'h0, s_reg.cnt, 3'b000};

    function automatic logic [63:0] gpr_word(input logic [28:0] k,
                                             input save_s_t s);
        logic [63:0] w;
        w = seg_base_first;
        if (k <= GPR_LAST_REG)
            w = gpr_val[k[3:0]];                                          // [RULE9]
        else if (k == SLOT_FLAGS)
            w = flags_val;                                                // [RULE10]
        else if (k == SLOT_IP)
            w = ip_val;                                                   // [RULE10]
        else if (k == SLOT_OUT_SP)
            w = s.osp;                                                    // [RULE11]
        else if (k == SLOT_OUT_FP)
            w = s.ofp;                                                    // [RULE12]
        else if (k == SLOT_EXIT_WORD)
            w = {RESERVED_HALF, exit_reason_word};                        // [RULE13]
        return w;
    endfunction : gpr_word

    always_comb
    begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        s_next.ok   = 1'b0;
        s_next.fail = 1'b0;
        s_next.rv   = 1'b0;
        // a write stays on the port untouched until memory takes it
        if (!stall)
        begin
            s_next.wr = 1'b0;
            case (s_reg.st)
                ST_IDLE:
                begin
                    if (async_exit_req)
                    begin
                        s_next.bsy   = 1'b1;
                        // base and offset assumed page aligned by software [RULE2]
                        s_next.frame = container_base + save_stack_offset // [RULE16] [RULE1]
                                       + (64'(s_reg.idx) * 64'(save_frame_length));
                        // software pads so this lands on a page end [RULE6] [RULE8]
                        s_next.gpr_base = container_base + save_stack_offset
                                          + (64'(s_reg.idx) * 64'(save_frame_length))
                                          + 64'(save_frame_length) - GPR_REGION_LEN; // [RULE5]
                        s_next.cnt = '0;
                        if (xs_words != 29'h0)
                            s_next.st = ST_XS;
                        else if (misc_on)
                            s_next.st = ST_MISC;
                        else
                            s_next.st = ST_GPR;
                    end
                    else if (entry_req)
                    begin
                        if (s_reg.idx < frame_slot_count)                 // [RULE18]
                        begin
                            s_next.ok  = 1'b1;
                            s_next.osp = cur_sp;                          // [RULE11]
                            s_next.ofp = cur_fp;                          // [RULE12]
                        end
                        else
                            s_next.fail = 1'b1;                           // [RULE18]
                    end
                    else if (resume_req && s_reg.idx != 32'h0)
                        s_next.idx = s_reg.idx - 32'h1;                   // [RULE17]
                end
                ST_XS:
                begin
                    s_next.wr    = 1'b1;
                    s_next.addr  = s_reg.frame + XS_IMAGE_OFS + slot_ofs; // [RULE3]
                    s_next.wdata = xs_data;
                    s_next.cnt   = s_reg.cnt + 29'h1;
                    if (s_reg.cnt == xs_words - 29'h1)
                    begin
                        s_next.cnt = '0;
                        s_next.st  = misc_on ? ST_MISC : ST_GPR;
                    end
                end
                ST_MISC:
                begin
                    s_next.wr    = 1'b1;
                    s_next.addr  = s_reg.gpr_base - MISC_COMP0_LEN + slot_ofs; // [RULE7]
                    s_next.wdata = (s_reg.cnt == 29'h0) ? misc_fault_addr
                                   : {RESERVED_HALF, misc_err_code};     // [RULE19]
                    s_next.cnt   = s_reg.cnt + 29'h1;
                    if (s_reg.cnt == MISC_LAST_SLOT)
                    begin
                        s_next.cnt = '0;
                        s_next.st  = ST_GPR;
                    end
                end
                ST_GPR:
                begin
                    s_next.wr    = 1'b1;
                    s_next.addr  = s_reg.gpr_base + slot_ofs;             // [RULE14]
                    s_next.wdata = gpr_word(s_reg.cnt, s_reg);
                    s_next.cnt   = s_reg.cnt + 29'h1;
                    // second segment base at 176 would spill into the next frame
                    if (s_reg.cnt == SLOT_SEG_FIRST)                      // [RULE15]
                        s_next.st = ST_FIN;
                end
                ST_FIN:
                begin
                    s_next.idx  = s_reg.idx + 32'h1;                      // [RULE17]
                    s_next.bsy  = 1'b0;
                    s_next.done = 1'b1;
                    s_next.rv   = 1'b1;                                   // [RULE11] [RULE12]
                    s_next.cnt  = '0;
                    s_next.st   = ST_IDLE;
                end
                default:
                    s_next = S_RST;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            s_reg <= S_RST;
        else
            s_reg <= s_next;
    end

    assign mem_wr              = s_reg.wr;
    assign mem_addr            = s_reg.addr;
    assign mem_wdata           = s_reg.wdata;
    assign xs_idx              = s_reg.cnt;
    assign busy                = s_reg.bsy;
    assign save_done           = s_reg.done;
    assign entry_ok            = s_reg.ok;
    assign entry_fail          = s_reg.fail;
    assign restore_valid       = s_reg.rv;
    assign restore_sp          = s_reg.osp;
    assign restore_fp          = s_reg.ofp;
    assign current_frame_index = s_reg.idx;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_idx_inc;
        s_reg.st == ST_FIN && !stall |=> s_reg.idx == $past(s_reg.idx) + 32'h1;
    endproperty
    a_idx_inc: assert property (p_idx_inc) else $error("index not raised on exit"); // [RULE17]

    property p_idx_dec;
        s_reg.st == ST_IDLE && !async_exit_req && !entry_req && resume_req
        && s_reg.idx != 32'h0 |=> s_reg.idx == $past(s_reg.idx) - 32'h1;
    endproperty
    a_idx_dec: assert property (p_idx_dec) else $error("index not lowered on resume"); // [RULE17]

    property p_entry_fail;
        s_reg.st == ST_IDLE && !async_exit_req && entry_req
        && s_reg.idx >= frame_slot_count |=> entry_fail && !entry_ok;
    endproperty
    a_entry_fail: assert property (p_entry_fail) else $error("entry not refused"); // [RULE18]

    property p_frame_addr;
        s_reg.st == ST_IDLE && async_exit_req |=> s_reg.frame == $past(container_base)
            + $past(save_stack_offset)
            + 64'($past(s_reg.idx)) * 64'($past(save_frame_length));
    endproperty
    a_frame_addr: assert property (p_frame_addr) else $error("bad frame address"); // [RULE16]

    property p_gpr_end;
        s_reg.st == ST_IDLE && async_exit_req |=>
            s_reg.gpr_base + GPR_REGION_LEN == s_reg.frame + 64'($past(save_frame_length));
    endproperty
    a_gpr_end: assert property (p_gpr_end) else $error("register region not at end"); // [RULE5]

    property p_xs_first;
        s_reg.st == ST_XS && s_reg.cnt == 29'h0 && !stall |=>
            mem_wr && mem_addr == s_reg.frame;
    endproperty
    a_xs_first: assert property (p_xs_first) else $error("image not at frame base"); // [RULE3]

    property p_flags_slot;
        s_reg.st == ST_GPR && s_reg.cnt == SLOT_FLAGS && !stall |=>
            mem_addr == s_reg.gpr_base + 64'h80 && mem_wdata == $past(flags_val);
    endproperty
    a_flags_slot: assert property (p_flags_slot) else $error("flags misplaced"); // [RULE10]

    property p_exit_slot;
        s_reg.st == ST_GPR && s_reg.cnt == SLOT_EXIT_WORD && !stall |=>
            mem_addr == s_reg.gpr_base + 64'ha0
            && mem_wdata == {32'h0, $past(exit_reason_word)};
    endproperty
    a_exit_slot: assert property (p_exit_slot) else $error("exit word misplaced"); // [RULE13]

    property p_no_misc;
        !misc_on && s_reg.st == ST_XS |=> s_reg.st != ST_MISC;
    endproperty
    a_no_misc: assert property (p_no_misc) else $error("unselected region written"); // [RULE19]

    property p_restore;
        restore_valid |-> $past(s_reg.st) == ST_FIN && !busy
            && current_frame_index == $past(s_reg.idx) + 32'h1;
    endproperty
    a_restore: assert property (p_restore) else $error("restore out of step"); // [RULE11]

    property p_wr_hold;
        mem_wr && !mem_ready |=> mem_wr && $stable(mem_addr) && $stable(mem_wdata);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("stalled write changed"); // [RULE1]

    c_save_misc:  cover property (s_reg.st == ST_MISC ##[1:300] save_done);
    c_entry_fail: cover property (entry_fail);
    c_stall:      cover property (mem_wr && !mem_ready ##1 mem_wr && mem_ready);
    c_resume:     cover property (save_done ##[1:50] resume_req);

endmodule : enclave_exit_state_save_frame

// file: pkg/frame_save_pkg.sv
package frame_save_pkg;

    // frame geometry, byte units
    localparam logic [63:0] XS_IMAGE_OFS      = 64'h0;    // image at frame base
    localparam logic [63:0] GPR_REGION_LEN    = 64'hb0;   // 176 bytes at frame end
    localparam logic [63:0] MISC_COMP0_LEN    = 64'h10;   // first component, 16 bytes
    localparam logic [63:0] WORD_BYTES        = 64'h8;
    localparam int          WORD_SHIFT        = 3;

    // general-register region word slots (offset / 8), then the last slot of component 0
    localparam logic [28:0] GPR_LAST_REG      = 29'h0f;   // r15 at 120
    localparam logic [28:0] SLOT_FLAGS        = 29'h10;   // 128
    localparam logic [28:0] SLOT_IP           = 29'h11;   // 136
    localparam logic [28:0] SLOT_OUT_SP       = 29'h12;   // 144
    localparam logic [28:0] SLOT_OUT_FP       = 29'h13;   // 152
    localparam logic [28:0] SLOT_EXIT_WORD    = 29'h14;   // 160, reserved upper half
    localparam logic [28:0] SLOT_SEG_FIRST    = 29'h15;   // 168
    localparam logic [28:0] MISC_LAST_SLOT    = 29'h01;   // two words in component 0

    localparam int          MISC_COMP0_BIT    = 0;
    localparam logic [31:0] RESERVED_HALF     = 32'h0;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_XS   = 5'h02,
        ST_MISC = 5'h04,
        ST_GPR  = 5'h08,
        ST_FIN  = 5'h10
    } save_state_t;

endpackage : frame_save_pkg

// file: dv/save_frame_mem.sv
`timescale 1ns/100ps
// behavioural store for the frame stack; a slow setting stalls every other cycle
module save_frame_mem
(
    input  wire logic        mclk,      // core clock
    input  wire logic        rst_b,     // async reset, active low
    input  wire logic        slow,      // stall every second cycle
    input  wire logic        mem_wr,    // write request
    input  wire logic [63:0] mem_addr,  // byte address
    input  wire logic [63:0] mem_wdata, // write word
    output logic             mem_ready  // write taken this cycle
);
    logic [63:0] store [logic [63:0]];
    int          wr_cnt;
    logic        tog_reg;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            tog_reg <= 1'b0;
        else
            tog_reg <= ~tog_reg;
    end

    assign mem_ready = slow ? tog_reg : 1'b1;

    // a write counts only at an edge where both sides agree
    always @(posedge mclk)
    begin
        if (rst_b && mem_wr && mem_ready)
        begin
            store[mem_addr] = mem_wdata;
            wr_cnt++;
        end
    end
endmodule : save_frame_mem

// file: dv/test_enclave_exit_state_save_frame.sv
`timescale 1ns/100ps
module test_enclave_exit_state_save_frame;
    import frame_save_pkg::*;
    logic              mclk, rst_b, async_exit_req, entry_req, resume_req, slow, mem_ready;
    logic              mem_wr, busy, save_done, entry_ok, entry_fail, restore_valid;
    logic [63:0]       container_base, save_stack_offset, xs_data, misc_fault_addr;
    logic [63:0]       flags_val, ip_val, seg_base_first, cur_sp, cur_fp, sp_in, fp_in;
    logic [63:0]       mem_addr, mem_wdata, restore_sp, restore_fp;
    logic [31:0]       save_frame_length, frame_slot_count, xs_size_bytes, misc_enum;
    logic [31:0]       extended_info_select, misc_err_code, exit_reason_word;
    logic [31:0]       current_frame_index;
    logic [15:0][63:0] gpr_val;
    logic [28:0]       xs_idx;
    int                error_cnt, checked, cyc;

    // image words carry their own index so misplaced words show up
    assign xs_data = 64'ha5a5_0000_0000_0000 | {35'h0, xs_idx};

    enclave_exit_state_save_frame u_enclave_exit_state_save_frame (
        .mclk, .rst_b, .async_exit_req, .entry_req, .resume_req, .container_base,
        .save_stack_offset, .save_frame_length, .frame_slot_count, .xs_size_bytes,
        .xs_data, .misc_enum, .extended_info_select, .misc_fault_addr, .misc_err_code,
        .gpr_val, .flags_val, .ip_val, .exit_reason_word, .seg_base_first, .cur_sp,
        .cur_fp, .mem_ready, .mem_wr, .mem_addr, .mem_wdata, .xs_idx, .busy, .save_done,
        .entry_ok, .entry_fail, .restore_valid, .restore_sp, .restore_fp,
        .current_frame_index);

    save_frame_mem u_save_frame_mem (.mclk, .rst_b, .slow, .mem_wr, .mem_addr, .mem_wdata,
        .mem_ready);

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [63:0] rd(input logic [63:0] a);
        return u_save_frame_mem.store.exists(a) ? u_save_frame_mem.store[a] : 64'hx;
    endfunction : rd

    task automatic do_entry(input logic ok);
        @(posedge mclk);
        #1;
        entry_req = 1'b1;
        sp_in = cur_sp;
        fp_in = cur_fp;
        @(posedge mclk);
        #1;
        entry_req = 1'b0;
        check("entry_ok", entry_ok, ok);
        check("entry_fail", entry_fail, !ok);
        if (ok)
            check("restore_sp", restore_sp, sp_in);
    endtask : do_entry

    task automatic do_resume(input logic [31:0] exp);
        @(posedge mclk);
        #1;
        resume_req = 1'b1;
        @(posedge mclk);
        #1;
        resume_req = 1'b0;
        check("index", current_frame_index, exp);
    endtask : do_resume

    // pointers are changed after entry, so only captured values may land in the frame
    task automatic do_exit(input logic [31:0] idx, input logic misc_on, input logic slow_in);
        logic [63:0] frame;
        logic [63:0] gbase;
        logic [63:0] mb;
        int          n;
        frame = 64'h10_0000 + 64'h2000 + {32'h0, idx} * 64'h2000;
        gbase = frame + 64'h2000 - 64'hb0;
        mb = gbase - 64'h10;
        @(posedge mclk);
        #1;
        u_save_frame_mem.store.delete();
        u_save_frame_mem.wr_cnt = 0;
        slow = slow_in;
        async_exit_req = 1'b1;
        @(posedge mclk);
        #1;
        async_exit_req = 1'b0;
        check("busy", busy, 1'b1);
        n = 0;
        while (save_done !== 1'b1 && n < 300)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("save_done", save_done, 1'b1);
        check("busy_end", busy, 1'b0);
        check("restore_valid", restore_valid, 1'b1);
        check("restore_sp", restore_sp, sp_in);
        check("restore_fp", restore_fp, fp_in);
        check("index", current_frame_index, idx + 32'h1);
        for (int k = 0; k < 8; k++)
            check("image", rd(frame + 64'h8 * k), 64'ha5a5_0000_0000_0000 | k);
        for (int k = 0; k < 16; k++)
            check("gpr", rd(gbase + 64'h8 * k), gpr_val[k]);
        check("flags", rd(gbase + 64'h80), flags_val);
        check("ip", rd(gbase + 64'h88), ip_val);
        check("out_sp", rd(gbase + 64'h90), sp_in);
        check("out_fp", rd(gbase + 64'h98), fp_in);
        check("exit_word", rd(gbase + 64'ha0), {32'h0, exit_reason_word});
        check("seg_first", rd(gbase + 64'ha8), seg_base_first);
        check("past_end", u_save_frame_mem.store.exists(gbase + 64'hb0), 1'b0);
        check("misc_here", u_save_frame_mem.store.exists(mb), misc_on);
        if (misc_on)
            check("misc_err", rd(mb + 64'h8), {32'h0, misc_err_code});
        if (misc_on)
            check("misc_addr", rd(mb), misc_fault_addr);
        check("writes", u_save_frame_mem.wr_cnt, 30 + (misc_on ? 2 : 0));
    endtask : do_exit

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    initial
    begin
        {rst_b, async_exit_req, entry_req, resume_req, slow} = 5'h0;
        container_base = 64'h10_0000;
        save_stack_offset = 64'h2000;
        save_frame_length = 32'h2000;
        xs_size_bytes = 32'h40;
        {misc_enum, extended_info_select, frame_slot_count} = 96'h0;
        misc_fault_addr = 64'hfa17_0000_1234_5678;
        misc_err_code = 32'h0000_0007;
        for (int k = 0; k < 16; k++)
            gpr_val[k] = 64'h1111_0000_0000_0000 + k;
        flags_val = 64'h0246;
        ip_val = 64'h7000_0040_1000;
        exit_reason_word = 32'h8000_030e;
        seg_base_first = 64'h5eb0_0000_8000;
        cur_sp = 64'h7ff0_0000_1000;
        cur_fp = 64'h7ff0_0000_2000;
        repeat (4) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        check("idle_busy", busy, 1'b0);
        check("idle_wr", mem_wr, 1'b0);
        check("idle_index", current_frame_index, 32'h0);
        do_entry(1'b0);
        frame_slot_count = 32'h2;
        do_entry(1'b1);
        cur_sp = 64'hdead_0000_0001;
        cur_fp = 64'hdead_0000_0002;
        extended_info_select = 32'h1;
        do_exit(32'h0, 1'b0, 1'b0);
        misc_enum = 32'h1;
        do_exit(32'h1, 1'b1, 1'b1);
        do_resume(32'h1);
        do_resume(32'h0);
        do_resume(32'h0);
        extended_info_select = 32'h0;
        do_exit(32'h0, 1'b0, 1'b1);
        give_verdict();
    end
endmodule : test_enclave_exit_state_save_frame
